/* src/mdce_pkg.sv */
`default_nettype none
package mdce_pkg;

  localparam int NCH_DEF = 32;
  localparam int CNT_W   = 10;
  localparam int CH_W    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets within the slave window.
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_BASE     = 8'h04;
  localparam logic [7:0] OFS_ALTB     = 8'h08;
  localparam logic [7:0] OFS_ENSET    = 8'h0c;
  localparam logic [7:0] OFS_ENCLR    = 8'h10;
  localparam logic [7:0] OFS_SWREQ    = 8'h14;
  localparam logic [7:0] OFS_ATTR     = 8'h20;
  localparam logic [7:0] ATTR_STRIDE  = 8'h08;
  localparam logic [7:0] ATTR_CLR_OFS = 8'h04;
  localparam logic [7:0] OFS_DONE     = 8'h40;
  localparam logic [7:0] OFS_ERR      = 8'h44;
  localparam logic [7:0] OFS_STAT     = 8'h48;
  localparam int         STAT_BUSY    = 8;

  // Channel attribute flags.
  localparam int ATTR_N  = 4;
  localparam int A_BURST = 0;
  localparam int A_ALT   = 1;
  localparam int A_HIPRI = 2;
  localparam int A_MASK  = 3;

  // Control table layout: 1024-byte aligned, alternate half at bit 9.
  localparam int TBL_ALIGN = 10;
  localparam int ALT_BIT   = 9;

  // Descriptor control word fields.
  localparam int CTL_MODE = 0;
  localparam int CTL_SIZE = 4;
  localparam int CTL_SINC = 6;
  localparam int CTL_DINC = 8;
  localparam int CTL_CNT  = 16;

  localparam logic [2:0] MODE_STOP  = 3'h0;
  localparam logic [2:0] MODE_BASIC = 3'h1;
  localparam logic [2:0] MODE_AUTO  = 3'h2;
  localparam logic [2:0] MODE_PING  = 3'h3;
  localparam logic [2:0] MODE_MSG   = 3'h4;
  localparam logic [2:0] MODE_MSGA  = 3'h5;
  localparam logic [2:0] MODE_PSG   = 3'h6;
  localparam logic [2:0] MODE_PSGA  = 3'h7;

  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] INC_HALF = 2'h1;
  localparam logic [1:0] INC_WORD = 2'h2;
  localparam logic [1:0] INC_NONE = 2'h3;
  localparam logic [1:0] SG_LAST  = 2'h3;

  localparam logic        CFG_RST  = 1'b0;
  localparam logic [21:0] BASE_RST = 22'h0;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mdce_mreq_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } mdce_mrsp_t;

endpackage
`default_nettype wire

/* src/mdce_arb.sv */
`timescale 1ns/1ps
`default_nettype none
module mdce_arb
  import mdce_pkg::*;
#(
  parameter int NCH = NCH_DEF
)
(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic [NCH-1:0]  pending,
  input  wire logic [NCH-1:0]  hipri,
  output logic                 valid,
  output logic [CH_W-1:0]      idx
);

  logic [NCH-1:0] hi_pend;

  // Lowest index wins within a priority level.
  function automatic logic [CH_W-1:0] first_set(input logic [NCH-1:0] v);
    logic [CH_W-1:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = CH_W'(i);
      end
    end
    return r;
  endfunction

  assign hi_pend = pending & hipri;
  assign valid   = |pending;
  assign idx     = (|hi_pend) ? first_set(hi_pend) : first_set(pending);

  property p_hi_first;
    @(posedge core_clk) disable iff (rst)
    (|hi_pend) |-> hipri[idx] && pending[idx];
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("default channel beat a raised one");

endmodule
`default_nettype wire

/* src/mdce_engine.sv */
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Basic mode started by a peripheral moves items only while its request stays asserted; a software request runs it to the end.
// - Auto-request mode runs the whole transfer once started.
// - Ping-pong alternates primary and alternate descriptors on each completion.
// - Memory scatter/gather runs a task list through the alternate descriptor.
// - Peripheral scatter/gather does the same, paced by the peripheral request.
// - Item widths of 8, 16 and 32 bits chosen per descriptor.
// - Addresses step by byte, half-word, word or stay fixed.
// - Two priority levels; raised-priority channels win arbitration.
// - Engine bus accesses wait while the processor uses the bus.
// - Software request on every channel; peripheral requests maskable per channel.
// - Full control table spans 1024 bytes for all channels and modes.
// - Engine clears enable at basic, auto and scatter/gather list completion, not at ping-pong completion; software re-arms or disables any time.
// - Remaining item count is written back and reads zero when done.
// - A finished descriptor's mode field reads stopped.
// - Channel enable state is readable.
// - Engine interrupt only for software transfers and errors.
// - Completion flags clear themselves when read.
// - Error flag and interrupt hold until software clears them.
// - Basic and auto use the primary or alternate per alternate select; complex modes use the alternate too.
// - No transfers until the engine is globally enabled.
// - Per-channel attribute flags can be set, cleared and read.
// - Attributes: burst only, alternate select, raised priority, request mask.
module mdce_engine
  import mdce_pkg::*;
#(
  parameter int NCH = NCH_DEF
)
(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  input  wire logic [NCH-1:0]  periph_req,
  input  wire logic [NCH-1:0]  periph_burst,
  input  wire logic            cpu_bus_busy,
  output mdce_mreq_t           mreq,
  input  wire mdce_mrsp_t      mrsp,
  output logic [NCH-1:0]       periph_done,
  output logic                 engine_irq
);

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_RD, S_WR, S_WB} mdce_state_t;

  logic [NCH-1:0]            en_reg;
  logic [NCH-1:0]            swp_reg;
  logic [NCH-1:0]            run_reg;
  logic [NCH-1:0]            swo_reg;
  logic [NCH-1:0]            done_reg;
  logic [NCH-1:0]            pdone_reg;
  logic [ATTR_N-1:0][NCH-1:0] attr_reg;
  logic                      gen_reg;
  logic                      err_reg;
  logic                      irq_reg;
  logic [31:TBL_ALIGN]       base_reg;
  logic                      wr_pend_reg;
  logic [7:0]                wr_ofs_reg;
  logic [31:0]               rdata_reg;
  mdce_state_t               state_reg;
  logic [CH_W-1:0]           ch_reg;
  logic                      alt_reg;
  logic [1:0]                widx_reg;
  logic [1:0]                pass_reg;
  logic [31:0]               src_reg;
  logic [31:0]               dst_reg;
  logic [31:0]               ctl_reg;
  logic [31:0]               data_reg;
  mdce_mreq_t                mreq_reg;

  logic                      rd_take;
  logic [7:0]                rd_ofs;
  logic [NCH-1:0]            hw_eff;
  logic [NCH-1:0]            pend;
  logic                      arb_valid;
  logic [CH_W-1:0]           arb_idx;
  logic [NCH-1:0]            ch_oh;
  logic [NCH-1:0]            take_oh;
  logic [2:0]                mode;
  logic [CNT_W-1:0]          cnt;
  logic [CNT_W-1:0]          cnt_dec;
  logic                      is_sg_pri;
  logic                      is_sg_alt;
  logic                      single_shot;
  logic                      mem_done;
  logic                      err_now;
  logic                      fetch_last;
  logic                      fetch_stop;
  logic                      last_wb;
  logic                      ev_now;
  logic                      clr_now;
  logic                      tog_now;
  logic                      keep_going;
  logic [NCH-1:0]            run_set;
  mdce_mreq_t                acc;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic wr_hit(input logic [7:0] ofs);
    return wr_pend_reg && (wr_ofs_reg == ofs);
  endfunction

  function automatic logic [31:0] inc_amt(input logic [1:0] inc);
    case (inc)
      INC_NONE: return 32'h0;
      INC_WORD: return 32'h4;
      INC_HALF: return 32'h2;
      default:  return 32'h1;
    endcase
  endfunction

  function automatic logic [31:0] desc_addr(input logic alt, input logic [CH_W-1:0] ch,
                                            input logic [1:0] w);
    return {base_reg, alt, ch, w, 2'b00};
  endfunction

  function automatic logic [31:0] rd_val(input logic [7:0] ofs);
    case (ofs)
      OFS_CFG:             return 32'(gen_reg);
      OFS_BASE:            return {base_reg, {TBL_ALIGN{1'b0}}};
      OFS_ALTB:            return {base_reg, 1'b1, {ALT_BIT{1'b0}}};
      OFS_ENSET, OFS_ENCLR: return 32'(en_reg);
      OFS_SWREQ:           return 32'(swp_reg);
      OFS_DONE:            return 32'(done_reg);
      OFS_ERR:             return 32'(err_reg);
      OFS_STAT:            return {23'h0, state_reg != S_IDLE, 3'h0, ch_reg};
      default:
      begin
        if (ofs[7:5] == OFS_ATTR[7:5])
        begin
          return 32'(attr_reg[ofs[4:3]]);
        end
        return 32'h0;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY, read data from a flop.

  assign rd_take   = hsel & hready & htrans[1] & ~hwrite;
  assign rd_ofs    = {haddr[7:2], 2'b00};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h0;
      rdata_reg   <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= hsel & hready & htrans[1] & hwrite;
      wr_ofs_reg  <= rd_ofs;
      rdata_reg   <= rd_take ? rd_val(rd_ofs) : 32'h0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      gen_reg  <= CFG_RST;
      base_reg <= BASE_RST;
      err_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end
    else
    begin
      if (wr_hit(OFS_CFG))
      begin
        gen_reg <= hwdata[0];
      end
      if (wr_hit(OFS_BASE))
      begin
        base_reg <= hwdata[31:TBL_ALIGN];
      end
      err_reg <= err_now | (err_reg & ~(wr_hit(OFS_ERR) & hwdata[0]));
      irq_reg <= (|done_reg) | err_reg;
    end
  end

  assign engine_irq  = irq_reg;
  assign periph_done = pdone_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel state. Hardware-set flags win over a clear in the same cycle.

  assign ch_oh   = NCH'(1) << ch_reg;
  assign take_oh = (state_reg == S_IDLE && arb_valid) ? NCH'(1) << arb_idx : '0;
  assign hw_eff  = ~attr_reg[A_MASK] & (periph_burst | (periph_req & ~attr_reg[A_BURST]));
  assign pend    = en_reg & {NCH{gen_reg}} & (swp_reg | run_reg | hw_eff);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      en_reg    <= '0;
      swp_reg   <= '0;
      run_reg   <= '0;
      swo_reg   <= '0;
      done_reg  <= '0;
      pdone_reg <= '0;
    end
    else
    begin
      en_reg <= (en_reg & ~(clr_now ? ch_oh : '0) & ~(wr_hit(OFS_ENCLR) ? hwdata[NCH-1:0] : '0))
                | (wr_hit(OFS_ENSET) ? hwdata[NCH-1:0] : '0);
      swp_reg <= (swp_reg & ~take_oh) | (wr_hit(OFS_SWREQ) ? hwdata[NCH-1:0] : '0);
      swo_reg <= ((swo_reg & ~(clr_now ? ch_oh : '0)) | (take_oh & swp_reg)) & en_reg;
      run_reg <= ((run_reg & ~(clr_now ? ch_oh : '0)) | run_set) & en_reg;
      done_reg <= (done_reg & ~((rd_take && rd_ofs == OFS_DONE) ? '1 : '0))
                  | ((ev_now && swo_reg[ch_reg]) ? ch_oh : '0);
      pdone_reg <= (ev_now && !swo_reg[ch_reg]) ? ch_oh : '0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      attr_reg <= '0;
    end
    else
    begin
      for (int k = 0; k < ATTR_N; k++)
      begin
        attr_reg[k] <= ((attr_reg[k]
          & ~(wr_hit(OFS_ATTR + ATTR_STRIDE * 8'(k) + ATTR_CLR_OFS) ? hwdata[NCH-1:0] : '0))
          | (wr_hit(OFS_ATTR + ATTR_STRIDE * 8'(k)) ? hwdata[NCH-1:0] : '0))
          ^ ((k == A_ALT && tog_now) ? ch_oh : '0);
      end
    end
  end

  mdce_arb #(.NCH(NCH)) u_arb (
    .core_clk (core_clk),
    .rst      (rst),
    .pending  (pend),
    .hipri    (attr_reg[A_HIPRI]),
    .valid    (arb_valid),
    .idx      (arb_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer decisions.

  assign mode        = ctl_reg[CTL_MODE +: 3];
  assign cnt         = ctl_reg[CTL_CNT +: CNT_W];
  assign cnt_dec     = cnt - CNT_W'(1);
  assign is_sg_pri   = !alt_reg && (mode == MODE_MSG || mode == MODE_PSG);
  assign is_sg_alt   = alt_reg && (mode == MODE_MSGA || mode == MODE_PSGA);
  assign single_shot = (mode == MODE_BASIC) || (mode == MODE_AUTO) || is_sg_pri;
  assign mem_done    = mreq_reg.req & mrsp.ack;
  assign err_now     = mem_done & mrsp.err;
  assign fetch_last  = state_reg == S_FETCH && mem_done && !mrsp.err && widx_reg == 2'h2;
  assign fetch_stop  = fetch_last && (mrsp.rdata[CTL_MODE +: 3] == MODE_STOP
                                      || mrsp.rdata[CTL_CNT +: CNT_W] == '0);
  assign last_wb     = state_reg == S_WB && mem_done && !mrsp.err && widx_reg == 2'h2;
  assign ev_now      = last_wb && cnt == '0 && (single_shot || mode == MODE_PING);
  assign clr_now     = fetch_stop | err_now | (last_wb && cnt == '0 && single_shot);
  // A primary scatter/gather pass that wrapped its task counter has loaded a task.
  assign tog_now     = last_wb && (cnt == '0 ? (mode == MODE_PING || is_sg_alt)
                                             : (is_sg_pri && pass_reg == 2'h0));
  // Auto, memory scatter/gather and software-started transfers keep running; others follow the request.
  assign keep_going  = cnt_dec != '0 && en_reg[ch_reg] && gen_reg
                       && (run_reg[ch_reg] | hw_eff[ch_reg])
                       && !(is_sg_pri && pass_reg == SG_LAST);
  assign run_set     = (fetch_last && !fetch_stop
                        && (mrsp.rdata[CTL_MODE +: 3] == MODE_AUTO
                            || mrsp.rdata[CTL_MODE +: 3] == MODE_MSG
                            || mrsp.rdata[CTL_MODE +: 3] == MODE_MSGA
                            || swo_reg[ch_reg])) ? ch_oh : '0;

  always_comb
  begin
    acc       = '0;
    acc.req   = 1'b1;
    acc.size  = SZ_WORD;
    acc.addr  = desc_addr(alt_reg, ch_reg, widx_reg);
    case (state_reg)
      S_RD:
      begin
        acc.size = ctl_reg[CTL_SIZE +: 2];
        acc.addr = src_reg;
      end
      S_WR:
      begin
        acc.write = 1'b1;
        acc.size  = ctl_reg[CTL_SIZE +: 2];
        acc.addr  = is_sg_pri ? desc_addr(1'b1, ch_reg, pass_reg) : dst_reg;
        acc.wdata = data_reg;
      end
      S_WB:
      begin
        acc.write = 1'b1;
        case (widx_reg)
          2'h0:    acc.wdata = src_reg;
          2'h1:    acc.wdata = dst_reg;
          default: acc.wdata = (cnt == '0) ? {ctl_reg[31:3], MODE_STOP} : ctl_reg;
        endcase
      end
      default:
      begin
        acc.req = state_reg == S_FETCH;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory master: one access in flight, held until acknowledged.

  assign mreq = mreq_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mreq_reg <= '0;
    end
    else if (mreq_reg.req)
    begin
      if (mrsp.ack)
      begin
        mreq_reg.req <= 1'b0;
      end
    end
    else if (acc.req && !cpu_bus_busy)
    begin
      mreq_reg <= acc;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      ch_reg    <= '0;
      alt_reg   <= 1'b0;
      widx_reg  <= 2'h0;
      pass_reg  <= 2'h0;
      src_reg   <= 32'h0;
      dst_reg   <= 32'h0;
      ctl_reg   <= 32'h0;
      data_reg  <= 32'h0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (arb_valid)
          begin
            ch_reg    <= arb_idx;
            alt_reg   <= attr_reg[A_ALT][arb_idx];
            widx_reg  <= 2'h0;
            state_reg <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          if (err_now)
          begin
            state_reg <= S_IDLE;
          end
          else if (mem_done)
          begin
            widx_reg <= widx_reg + 2'h1;
            case (widx_reg)
              2'h0:    src_reg <= mrsp.rdata;
              2'h1:    dst_reg <= mrsp.rdata;
              default: ctl_reg <= mrsp.rdata;
            endcase
            if (widx_reg == 2'h2)
            begin
              pass_reg  <= 2'h0;
              state_reg <= fetch_stop ? S_IDLE : S_RD;
            end
          end
        end
        S_RD:
        begin
          if (err_now)
          begin
            state_reg <= S_IDLE;
          end
          else if (mem_done)
          begin
            data_reg  <= mrsp.rdata;
            state_reg <= S_WR;
          end
        end
        S_WR:
        begin
          if (err_now)
          begin
            state_reg <= S_IDLE;
          end
          else if (mem_done)
          begin
            src_reg <= src_reg + inc_amt(ctl_reg[CTL_SINC +: 2]);
            if (!is_sg_pri)
            begin
              dst_reg <= dst_reg + inc_amt(ctl_reg[CTL_DINC +: 2]);
            end
            pass_reg                    <= pass_reg + 2'h1;
            ctl_reg[CTL_CNT +: CNT_W]   <= cnt_dec;
            widx_reg                    <= 2'h0;
            state_reg                   <= keep_going ? S_RD : S_WB;
          end
        end
        S_WB:
        begin
          if (err_now)
          begin
            state_reg <= S_IDLE;
          end
          else if (mem_done)
          begin
            widx_reg <= widx_reg + 2'h1;
            if (widx_reg == 2'h2)
            begin
              state_reg <= S_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_basic_halt;
    @(posedge core_clk) disable iff (rst)
    (state_reg == S_WR && mem_done && !mrsp.err && mode == MODE_BASIC
     && !run_reg[ch_reg] && !hw_eff[ch_reg]) |=> state_reg == S_WB;
  endproperty
  a_basic_halt: assert property (p_basic_halt) else $error("basic ran on without request");

  property p_auto_cont;
    @(posedge core_clk) disable iff (rst)
    (state_reg == S_WR && mem_done && !mrsp.err && mode == MODE_AUTO && cnt_dec != '0
     && en_reg[ch_reg] && gen_reg) |=> state_reg == S_RD;
  endproperty
  a_auto_cont: assert property (p_auto_cont) else $error("auto transfer stopped early");

  property p_ping_tog;
    @(posedge core_clk) disable iff (rst)
    (last_wb && cnt == '0 && mode == MODE_PING && !wr_pend_reg)
    |=> attr_reg[A_ALT][ch_reg] != $past(attr_reg[A_ALT][ch_reg]);
  endproperty
  a_ping_tog: assert property (p_ping_tog) else $error("ping-pong did not swap buffers");

  property p_sg_step;
    @(posedge core_clk) disable iff (rst)
    (state_reg == S_WR && mreq_reg.req && is_sg_pri)
    |-> mreq_reg.addr == desc_addr(1'b1, ch_reg, pass_reg) && mreq_reg.write;
  endproperty
  a_sg_step: assert property (p_sg_step) else $error("task not copied to alternate");

  property p_yield;
    @(posedge core_clk) disable iff (rst)
    (cpu_bus_busy && !mreq_reg.req) |=> !mreq_reg.req;
  endproperty
  a_yield: assert property (p_yield) else $error("engine took bus from processor");

  property p_en_clr;
    @(posedge core_clk) disable iff (rst)
    (clr_now && !wr_pend_reg) |=> !en_reg[ch_reg] && state_reg == S_IDLE;
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("enable not cleared at completion");

  property p_stop_wb;
    @(posedge core_clk) disable iff (rst)
    (state_reg == S_WB && mreq_reg.req && widx_reg == 2'h2 && cnt == '0)
    |-> mreq_reg.wdata[CTL_MODE +: 3] == MODE_STOP && mreq_reg.wdata[CTL_CNT +: CNT_W] == '0;
  endproperty
  a_stop_wb: assert property (p_stop_wb) else $error("finished descriptor not stopped");

  property p_sw_irq;
    @(posedge core_clk) disable iff (rst)
    (ev_now && swo_reg[ch_reg]) |=> done_reg[ch_reg] ##1 engine_irq;
  endproperty
  a_sw_irq: assert property (p_sw_irq) else $error("software completion gave no interrupt");

  property p_err_hold;
    @(posedge core_clk) disable iff (rst)
    (err_reg && !wr_pend_reg) |=> err_reg && engine_irq;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped by itself");

  property p_gen_off;
    @(posedge core_clk) disable iff (rst)
    (!gen_reg && state_reg == S_IDLE) |=> state_reg == S_IDLE;
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("transfer began while disabled");

endmodule
`default_nettype wire

/* dv/mdce_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module mdce_mem
  import mdce_pkg::*;
(
  input  wire logic       core_clk,
  input  wire mdce_mreq_t mreq,
  output mdce_mrsp_t      mrsp
);
  logic [31:0] mem [1024];
  logic [1:0]  wait_cnt = 2'h0;
  logic        slow = 1'b0;
  initial
  begin
    mrsp = '0;
  end
  // Answers alternate between prompt and slow; idle read data keeps changing so stale data fails.
  always @(posedge core_clk)
  begin
    mrsp.ack <= 1'b0;
    mrsp.rdata <= ~mrsp.rdata;
    if (mreq.req && !mrsp.ack)
    begin
      if (wait_cnt == {slow, 1'b0})
      begin
        mrsp.ack <= 1'b1;
        wait_cnt <= 2'h0;
        slow <= ~slow;
        if (mreq.write)
          mem[mreq.addr[11:2]] <= mreq.wdata;
        else
          mrsp.rdata <= mem[mreq.addr[11:2]];
      end
      else
        wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* dv/test_micro_dma_channel_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module test_micro_dma_channel_engine
  import mdce_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        cpu_bus_busy = 1'b0;
  logic        hreadyout, engine_irq, hresp;
  logic [31:0] periph_burst = 32'h0;
  logic [31:0] pdone_seen = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] periph_req = 32'h0;
  logic [31:0] hrdata, rd, periph_done;
  mdce_mreq_t  mreq;
  mdce_mrsp_t  mrsp;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          nreq = 0;
  int          n;
  mdce_engine i_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periph_req(periph_req),
    .periph_burst(periph_burst), .cpu_bus_busy(cpu_bus_busy), .mreq(mreq), .mrsp(mrsp),
    .periph_done(periph_done), .engine_irq(engine_irq));
  mdce_mem i_mem (.core_clk(core_clk), .mreq(mreq), .mrsp(mrsp));
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (mreq.req === 1'b1 && mrsp.ack === 1'b1)
      nreq++;
  // Completion pulses last one cycle, so they are gathered for a later check.
  always @(posedge core_clk)
    if (!rst)
      pdone_seen <= pdone_seen | periph_done;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1)
    begin
      n_fail++;
      conclude();
    end
  endtask
  // The address phase is held until hready, then the data phase until hready again.
  task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    hwrite <= wr_en;
    htrans <= 2'b10;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  initial
  begin
    #2_000_000;
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc("cfg", OFS_CFG, 32'h0);
    rdc("enables", OFS_ENSET, 32'h0);
    chk("response", 32'h0, {31'h0, hresp});
    wr(OFS_BASE, 32'h0000_0400);
    rdc("base", OFS_BASE, 32'h0000_0400);
    rdc("alt base", OFS_ALTB, 32'h0000_0600);
    rdc("unmapped", 8'h4c, 32'h0);
    for (int k = 0; k < ATTR_N; k++)
    begin
      logic [7:0] ao;
      ao = 8'(OFS_ATTR + ATTR_STRIDE * k);
      wr(ao, 32'h20);
      rdc("attr set", ao, 32'h20);
      wr(ao + ATTR_CLR_OFS, 32'h20);
      rdc("attr clear", ao, 32'h0);
    end
    $display("register test done");
    i_mem.mem[10'h100] = 32'h0000_0100;
    i_mem.mem[10'h101] = 32'h0000_0200;
    i_mem.mem[10'h102] = {16'h2, 6'h0, INC_WORD, INC_WORD, SZ_WORD, 1'b0, MODE_AUTO};
    i_mem.mem[10'h040] = 32'ha5a5_0001;
    i_mem.mem[10'h041] = 32'h5a5a_0002;
    wr(8'(OFS_ATTR + ATTR_STRIDE * A_MASK), 32'h2);
    wr(OFS_ENSET, 32'h3);
    periph_req <= 32'h2;
    wr(OFS_SWREQ, 32'h1);
    repeat (20) @(posedge core_clk);
    chk("accesses while disabled", 32'h0, nreq);
    cpu_bus_busy <= 1'b1;
    wr(OFS_CFG, 32'h1);
    repeat (20) @(posedge core_clk);
    chk("accesses while cpu busy", 32'h0, nreq);
    cpu_bus_busy <= 1'b0;
    wr(OFS_SWREQ, 32'h1);
    n = 0;
    while (engine_irq !== 1'b1 && n < 2000)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("irq raised", 32'h1, {31'h0, engine_irq});
    chk("accesses", 32'd10, nreq);
    chk("dst word 0", 32'ha5a5_0001, i_mem.mem[10'h080]);
    chk("dst word 1", 32'h5a5a_0002, i_mem.mem[10'h081]);
    chk("ctl", {16'h0, 6'h0, INC_WORD, INC_WORD, SZ_WORD, 1'b0, MODE_STOP}, i_mem.mem[10'h102]);
    rdc("enables after", OFS_ENSET, 32'h2);
    rdc("done", OFS_DONE, 32'h1);
    rdc("done cleared", OFS_DONE, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, engine_irq});
    chk("periph done", 32'h0, pdone_seen);
    periph_burst <= 32'h2;
    repeat (20) @(posedge core_clk);
    chk("accesses on masked burst", 32'd10, nreq);
    $display("transfer test done");
    conclude();
  end
endmodule
`default_nettype wire
